// ### common/vpef_pkg.sv
// Constants and types for the receive path event flag registers
// How it works
// - Path event byte at index 118A: trace, REI, UNEQ, PLM, C2, C2 unstable, RDI.
// - Pointer event byte at index 118B: B3, new, unknown, dec, inc, NDF, LOP, AIS.
// - Flags show events since last read; a read returns them, then clears, keeping new events.
// - Path bit 7 sets when a new path trace message is accepted.
// - Path bit 6 sets on every remote error indication event.
// - Path bit 5 sets when unequipped is declared and when cleared.
// - Path bit 4 sets when label mismatch is declared and when cleared.
// - Path bit 3 sets when a new signal label byte is accepted.
// - Path bit 2 sets when label unstable is declared or cleared.
// - Path bit 1 sets when remote defect unstable is declared or cleared.
// - Path bit 0 sets on a new accepted remote defect value, readable at 1193 bits 6:4.
// - Status at 1187 mirrors unequipped bit 5, label unstable bit 6, RDI unstable bit 2.
// - Pointer bit 7 sets on every B3 parity error.
// - Pointer bit 6 sets on a new pointer, never for adjustments carrying NDF.
// - Pointer bit 5 sets for a pointer of no recognised kind, increment being one.
// - Decrement, NDF, all-ones and new pointers also suppress the unknown flag.
// - Pointer bits 4, 3 and 2 set on decrement, increment and NDF pointers.
// - Pointer bit 1 sets on LOP change, bit 0 on AU alarm change.
// - Interrupt output rises for a flag only when its enable bit is set.
`default_nettype none
package vpef_pkg;

    // ==========================================================
    // Address map
    localparam int ADDR_W = 16;
    localparam int IDX_W = 14;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 8;
    typedef logic [IDX_W-1:0] vpef_idx_t;
    typedef logic [FLAG_W-1:0] vpef_byte_t;

    // Register indices; byte address is four times the index
    localparam vpef_idx_t IDX_PATH_STATUS = 14'h1187;
    localparam vpef_idx_t IDX_PATH_EVT = 14'h118A;
    localparam vpef_idx_t IDX_PTR_EVT = 14'h118B;
    localparam vpef_idx_t IDX_PATH_EN = 14'h118E;
    localparam vpef_idx_t IDX_PTR_EN = 14'h118F;
    localparam vpef_idx_t IDX_RDI_VALUE = 14'h1193;

    // ==========================================================
    // Path event byte fields
    localparam int PE_TRACE = 7;
    localparam int PE_REI = 6;
    localparam int PE_UNEQ = 5;
    localparam int PE_PLM = 4;
    localparam int PE_LABEL = 3;
    localparam int PE_LABEL_UNST = 2;
    localparam int PE_RDI_UNST = 1;
    localparam int PE_RDI_NEW = 0;

    // Pointer event byte fields
    localparam int PT_B3 = 7;
    localparam int PT_NEW = 6;
    localparam int PT_UNKNOWN = 5;
    localparam int PT_DEC = 4;
    localparam int PT_INC = 3;
    localparam int PT_NDF = 2;
    localparam int PT_LOP = 1;
    localparam int PT_AIS = 0;

    // Live status byte fields
    localparam int ST_LABEL_UNST = 6;
    localparam int ST_UNEQ = 5;
    localparam int ST_RDI_UNST = 2;
    localparam int ST_LOP = 1;
    localparam int ST_AIS = 0;

    // Accepted remote defect value field
    localparam int RDI_LSB = 4;
    localparam int RDI_W = 3;

    // ==========================================================
    // Reset values and bus answers
    localparam vpef_byte_t FLAG_RESET = 8'h00;
    localparam vpef_byte_t EN_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : vpef_pkg
`default_nettype wire

// ### logic/vpef_flag_reg.sv
// Clear-on-read sticky flag byte
`timescale 1ns/1ps
`default_nettype none
module vpef_flag_reg
    import vpef_pkg::*;
#(
    parameter int WIDTH = FLAG_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Event pulses and read strobe
    input wire logic [WIDTH-1:0] setPulse,
    input wire logic clearRead,
    // Sticky flags
    output logic [WIDTH-1:0] flags_reg
);

    // ==========================================================
    // One sticky bit per event
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                flags_reg[i] <= FLAG_RESET[i];
            // pulse sets, only a read clears
            end else if (setPulse[i]) begin
                flags_reg[i] <= 1'b1;
            end else if (clearRead) begin
                flags_reg[i] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Checks
    property p_set_wins;
        @(posedge clk_sys) disable iff (rst)
        (|setPulse) |=> ((flags_reg & $past(setPulse)) == $past(setPulse));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost in read cycle");

    property p_sticky;
        @(posedge clk_sys) disable iff (rst)
        !clearRead |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg));
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without read");

endmodule : vpef_flag_reg
`default_nettype wire

// ### logic/vpef_event_flags.sv
// Receive path event flag registers with AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none
module vpef_event_flags
    import vpef_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Path event pulses from the overhead detectors
    input wire logic traceAcceptPulse,
    input wire logic reiEventPulse,
    input wire logic uneqChangePulse,
    input wire logic plmChangePulse,
    input wire logic newLabelPulse,
    input wire logic labelUnstableChangePulse,
    input wire logic rdiUnstableChangePulse,
    input wire logic newRdiValuePulse,
    // Pointer and error event pulses
    input wire logic b3ErrorPulse,
    input wire logic newPointerPulse,
    input wire logic unknownPointerPulse,
    input wire logic ptrDecrementPulse,
    input wire logic ptrIncrementPulse,
    input wire logic ndfPointerPulse,
    input wire logic aisPointerPulse,
    input wire logic lopChangePulse,
    input wire logic aisChangePulse,
    // Live defect states
    input wire logic uneqDefect,
    input wire logic labelUnstableDefect,
    input wire logic rdiUnstableDefect,
    input wire logic lopDefect,
    input wire logic aisDefect,
    input wire logic [RDI_W-1:0] acceptedRemoteDefectValue,
    // Interrupt
    output logic irq_reg
);

    // ==========================================================
    // Declarations
    vpef_byte_t pathSet;
    vpef_byte_t ptrSet;
    vpef_byte_t pathFlags;
    vpef_byte_t ptrFlags;
    vpef_byte_t pathEn_reg;
    vpef_byte_t ptrEn_reg;
    vpef_byte_t statusLive;
    logic recognisedPointer;
    logic arFire;
    logic rFire;
    logic bFire;
    logic doWrite;
    vpef_idx_t rdIdx;
    vpef_idx_t wrIdx;
    logic clearPathEvt;
    logic clearPtrEvt;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [ADDR_W-1:0] awAddr_reg;
    logic [DATA_W-1:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic [DATA_W-1:0] rdataNext;
    logic [1:0] rrespNext;
    logic irqNext;

    // ==========================================================
    // Event gathering
    // any one of these is a known pointer kind
    // decrement, NDF, all-ones and new also count as known
    assign recognisedPointer = ptrIncrementPulse | ptrDecrementPulse | ndfPointerPulse
        | aisPointerPulse | newPointerPulse;

    // Path event byte, one pulse per bit
    always_comb begin
        pathSet = FLAG_RESET;
        pathSet[PE_TRACE] = traceAcceptPulse;
        pathSet[PE_REI] = reiEventPulse;
        pathSet[PE_UNEQ] = uneqChangePulse;
        pathSet[PE_PLM] = plmChangePulse;
        pathSet[PE_LABEL] = newLabelPulse;
        pathSet[PE_LABEL_UNST] = labelUnstableChangePulse;
        pathSet[PE_RDI_UNST] = rdiUnstableChangePulse;
        pathSet[PE_RDI_NEW] = newRdiValuePulse;
    end

    // Pointer event byte; detector quirks filtered here so a flag never lies
    always_comb begin
        ptrSet = FLAG_RESET;
        ptrSet[PT_B3] = b3ErrorPulse;
        // NDF adjustments are not new pointers
        ptrSet[PT_NEW] = newPointerPulse & ~ndfPointerPulse;
        // only pointers of no known kind
        ptrSet[PT_UNKNOWN] = unknownPointerPulse & ~recognisedPointer;
        ptrSet[PT_DEC] = ptrDecrementPulse;
        ptrSet[PT_INC] = ptrIncrementPulse;
        ptrSet[PT_NDF] = ndfPointerPulse;
        // LOP and AU alarm either edge
        ptrSet[PT_LOP] = lopChangePulse;
        ptrSet[PT_AIS] = aisChangePulse;
    end

    // ==========================================================
    // Flag storage
    // path event byte
    vpef_flag_reg #(
        .WIDTH(FLAG_W)
    ) u_path_flags (
        .clk_sys(clk_sys),
        .rst(rst),
        .setPulse(pathSet),
        .clearRead(clearPathEvt),
        .flags_reg(pathFlags)
    );

    vpef_flag_reg #(
        .WIDTH(FLAG_W)
    ) u_ptr_flags (
        .clk_sys(clk_sys),
        .rst(rst),
        .setPulse(ptrSet),
        .clearRead(clearPtrEvt),
        .flags_reg(ptrFlags)
    );

    // ==========================================================
    // Live status byte
    // live defect mirror
    always_comb begin
        statusLive = FLAG_RESET;
        statusLive[ST_LABEL_UNST] = labelUnstableDefect;
        statusLive[ST_UNEQ] = uneqDefect;
        statusLive[ST_RDI_UNST] = rdiUnstableDefect;
        statusLive[ST_LOP] = lopDefect;
        statusLive[ST_AIS] = aisDefect;
    end

    // ==========================================================
    // Read channel
    assign arFire = s_axi_arvalid & s_axi_arready;
    assign rFire = s_axi_rvalid & s_axi_rready;
    assign rdIdx = s_axi_araddr[ADDR_W-1:2];

    // the read that samples a byte also clears it
    assign clearPathEvt = arFire && (rdIdx == IDX_PATH_EVT);
    assign clearPtrEvt = arFire && (rdIdx == IDX_PTR_EVT);

    // Read mux; unmapped words answer zero with a slave error
    always_comb begin
        rdataNext = '0;
        rrespNext = RESP_OKAY;
        unique case (rdIdx)
            IDX_PATH_STATUS: rdataNext[FLAG_W-1:0] = statusLive;
            IDX_PATH_EVT: rdataNext[FLAG_W-1:0] = pathFlags;
            IDX_PTR_EVT: rdataNext[FLAG_W-1:0] = ptrFlags;
            IDX_PATH_EN: rdataNext[FLAG_W-1:0] = pathEn_reg;
            IDX_PTR_EN: rdataNext[FLAG_W-1:0] = ptrEn_reg;
            IDX_RDI_VALUE: rdataNext[RDI_LSB +: RDI_W] = acceptedRemoteDefectValue;
            default: rrespNext = RESP_SLVERR;
        endcase
    end

    // One read at a time; address accepted only while no data is pending
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (arFire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdataNext;
            s_axi_rresp <= rrespNext;
        end else if (rFire) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Write channel
    assign bFire = s_axi_bvalid & s_axi_bready;
    assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
    assign wrIdx = awAddr_reg[ADDR_W-1:2];

    // Address and data are captured independently, in either order
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            awHeld_reg <= 1'b0;
            awAddr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_reg <= 1'b0;
        end else if (bFire) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Data side of the write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_wready <= 1'b1;
            wHeld_reg <= 1'b0;
            wData_reg <= '0;
            wStrb_reg <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_reg <= 1'b0;
        end else if (bFire) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Response; writes to flag and status bytes are ignored but answered OKAY
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            unique case (wrIdx)
                IDX_PATH_STATUS, IDX_PATH_EVT, IDX_PTR_EVT, IDX_PATH_EN, IDX_PTR_EN, IDX_RDI_VALUE:
                    s_axi_bresp <= RESP_OKAY;
                default: s_axi_bresp <= RESP_SLVERR;
            endcase
        end else if (bFire) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Enable bytes; only the low lane carries them
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pathEn_reg <= EN_RESET;
            ptrEn_reg <= EN_RESET;
        end else if (doWrite && wStrb_reg[0]) begin
            if (wrIdx == IDX_PATH_EN) begin
                pathEn_reg <= wData_reg[FLAG_W-1:0];
            end
            if (wrIdx == IDX_PTR_EN) begin
                ptrEn_reg <= wData_reg[FLAG_W-1:0];
            end
        end
    end

    // ==========================================================
    // Interrupt
    // only enabled flags reach the pin
    assign irqNext = |(pathFlags & pathEn_reg) | |(ptrFlags & ptrEn_reg);

    // Registered so the pin never glitches on decode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irqNext;
        end
    end

    // ==========================================================
    // Checks
    property p_read_clears;
        @(posedge clk_sys) disable iff (rst)
        (clearPathEvt && pathSet == FLAG_RESET) |=> (pathFlags == FLAG_RESET);
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("path byte not cleared by read");

    property p_read_snapshot;
        @(posedge clk_sys) disable iff (rst)
        clearPtrEvt |=> (s_axi_rvalid && s_axi_rdata[FLAG_W-1:0] == $past(ptrFlags));
    endproperty
    a_read_snapshot: assert property (p_read_snapshot) else $error("pointer read data wrong");

    property p_irq_gate;
        @(posedge clk_sys) disable iff (rst)
        ((pathFlags & pathEn_reg) == FLAG_RESET && (ptrFlags & ptrEn_reg) == FLAG_RESET) |=> !irq_reg;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enabled flag");

    property p_status_mirror;
        @(posedge clk_sys) disable iff (rst)
        (arFire && rdIdx == IDX_PATH_STATUS) |=> (s_axi_rdata[ST_UNEQ] == $past(uneqDefect)
            && s_axi_rdata[ST_LABEL_UNST] == $past(labelUnstableDefect));
    endproperty
    a_status_mirror: assert property (p_status_mirror) else $error("status byte not live");

    property p_ndf_not_new;
        @(posedge clk_sys) disable iff (rst)
        (newPointerPulse && ndfPointerPulse && !ptrFlags[PT_NEW]) |=> !ptrFlags[PT_NEW];
    endproperty
    a_ndf_not_new: assert property (p_ndf_not_new) else $error("NDF set new pointer flag");

    property p_unknown_excluded;
        @(posedge clk_sys) disable iff (rst)
        (unknownPointerPulse && recognisedPointer && !ptrFlags[PT_UNKNOWN]) |=> !ptrFlags[PT_UNKNOWN];
    endproperty
    a_unknown_excluded: assert property (p_unknown_excluded) else $error("known pointer flagged unknown");

    property p_b3_sets;
        @(posedge clk_sys) disable iff (rst)
        b3ErrorPulse |=> ptrFlags[PT_B3] ##1 (ptrFlags[PT_B3] || $past(clearPtrEvt));
    endproperty
    a_b3_sets: assert property (p_b3_sets) else $error("B3 flag not held");

    property p_write_answer;
        @(posedge clk_sys) disable iff (rst)
        doWrite |=> (s_axi_bvalid && !s_axi_awready && !s_axi_wready);
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write answer missing");

    property p_rdata_hold;
        @(posedge clk_sys) disable iff (rst)
        (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata));
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed before taken");

endmodule : vpef_event_flags
`default_nettype wire

// ### bench/vpef_det.sv
// Behavioural model of the receive pointer and overhead detectors
`timescale 1ns/1ps
`default_nettype none
module vpef_det (
    // Clock
    input wire logic clk_sys,
    // Event pulses in register bit order
    output logic [7:0] pathPulse,
    output logic [7:0] ptrPulse,
    output logic aisPtrPulse,
    // Levels: label unstable, unequipped, RDI unstable, LOP, AIS
    output logic [4:0] defects,
    output logic [2:0] rdiValue
);
    // ==========
    // Quiet lines from time zero
    initial begin
        pathPulse = 8'h00;
        ptrPulse = 8'h00;
        aisPtrPulse = 1'b0;
        defects = 5'h00;
        rdiValue = 3'h0;
    end

    // ==========
    // Levels move with their change pulse in the same cycle
    task automatic drive(input logic [7:0] pa, input logic [7:0] pt, input logic ap, input logic [4:0] lv,
                         input logic [2:0] rv);
        logic [4:0] tg;
        tg = lv ^ defects;
        @(posedge clk_sys);
        pathPulse <= pa | {2'h0, tg[3], 2'h0, tg[4], tg[2], |(rv ^ rdiValue)};
        ptrPulse <= pt | {6'h00, tg[1:0]};
        aisPtrPulse <= ap;
        defects <= lv;
        rdiValue <= rv;
        @(posedge clk_sys);
        pathPulse <= 8'h00;
        ptrPulse <= 8'h00;
        aisPtrPulse <= 1'b0;
    endtask : drive
endmodule : vpef_det
`default_nettype wire

// ### bench/vpef_event_flags_tb.sv
// Self-checking bench for the receive path event flag registers
`timescale 1ns/1ps
`default_nettype none
module vpef_event_flags_tb
    import vpef_pkg::*;
;
    // ==========
    // Bench signals and expectation tables
    logic clk_sys, rst;
    logic [ADDR_W-1:0] awAddr, arAddr;
    logic [DATA_W-1:0] wData, rData;
    logic [3:0] wStrb;
    logic [1:0] bResp, rResp;
    logic awValid, awReady, wValid, wReady, bValid, bReady;
    logic arValid, arReady, rValid, rReady, irq;
    logic [7:0] pathPulse, ptrPulse;
    logic aisPtrPulse;
    logic [4:0] defects;
    logic [2:0] rdiValue;
    vpef_byte_t kind;
    int fails, compares;
    localparam vpef_byte_t KINDS [4] = '{8'h40, 8'h10, 8'h08, 8'h04};
    localparam logic [4:0] LVS [3] = '{5'h15, 5'h0A, 5'h00};
    localparam vpef_byte_t STS [3] = '{8'h45, 8'h22, 8'h00};
    localparam vpef_byte_t PES [3] = '{8'h07, 8'h26, 8'h20};
    localparam vpef_byte_t PTS [3] = '{8'h01, 8'h03, 8'h02};

    vpef_event_flags i_vpef_event_flags (
        .clk_sys(clk_sys), .rst(rst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .traceAcceptPulse(pathPulse[7]), .reiEventPulse(pathPulse[6]), .uneqChangePulse(pathPulse[5]),
        .plmChangePulse(pathPulse[4]), .newLabelPulse(pathPulse[3]), .labelUnstableChangePulse(pathPulse[2]),
        .rdiUnstableChangePulse(pathPulse[1]), .newRdiValuePulse(pathPulse[0]),
        .b3ErrorPulse(ptrPulse[7]), .newPointerPulse(ptrPulse[6]), .unknownPointerPulse(ptrPulse[5]),
        .ptrDecrementPulse(ptrPulse[4]), .ptrIncrementPulse(ptrPulse[3]), .ndfPointerPulse(ptrPulse[2]),
        .lopChangePulse(ptrPulse[1]), .aisChangePulse(ptrPulse[0]), .aisPointerPulse(aisPtrPulse),
        .uneqDefect(defects[3]), .labelUnstableDefect(defects[4]), .rdiUnstableDefect(defects[2]),
        .lopDefect(defects[1]), .aisDefect(defects[0]), .acceptedRemoteDefectValue(rdiValue),
        .irq_reg(irq)
    );
    vpef_det i_vpef_det (.clk_sys(clk_sys), .pathPulse(pathPulse), .ptrPulse(ptrPulse),
        .aisPtrPulse(aisPtrPulse), .defects(defects), .rdiValue(rdiValue));

    // ==========
    // Comparisons; every result is widened to one word
    task automatic checkWord(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at time %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : checkWord
    task automatic checkResp(input logic [1:0] got, input logic [1:0] exp);
        checkWord({30'h0, got}, {30'h0, exp});
    endtask : checkResp
    // Interrupt lags flags and enables, so let it settle first
    task automatic checkIrq(input logic exp);
        repeat (3) @(posedge clk_sys);
        checkWord({31'h0, irq}, {31'h0, exp});
    endtask : checkIrq
    task automatic ev(input vpef_byte_t pa, input vpef_byte_t pt, input logic ap);
        i_vpef_det.drive(pa, pt, ap, defects, rdiValue);
    endtask : ev

    // ==========
    // Bus master; released payload is inverted so stale values never pass
    task automatic axiWrite(input vpef_idx_t idx, input vpef_byte_t val, input logic [3:0] strb, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge clk_sys);
        awAddr <= {idx, 2'b00};
        wData <= {24'h000000, val};
        wStrb <= strb;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (awValid && awReady) begin
                awValid <= 1'b0;
                awAddr <= ~awAddr;
            end
            if (wValid && wReady) begin
                wValid <= 1'b0;
                wData <= ~wData;
            end
            if (bValid) begin
                bReady <= 1'b0;
                done = 1'b1;
                checkResp(bResp, er);
            end
        end
    endtask : axiWrite
    task automatic axiRead(input vpef_idx_t idx, input vpef_byte_t ex, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge clk_sys);
        arAddr <= {idx, 2'b00};
        arValid <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (arValid && arReady) begin
                arValid <= 1'b0;
                arAddr <= ~arAddr;
            end
            // Ready comes one beat late, so the slave must hold its answer
            if (rValid && rReady) begin
                rReady <= 1'b0;
                done = 1'b1;
                checkWord(rData, {24'h000000, ex});
                checkResp(rResp, er);
            end else if (rValid) begin
                rReady <= 1'b1;
            end
        end
    endtask : axiRead

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // ==========
    // Clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        {awAddr, arAddr} = 32'h00000000;
        wData = 32'h00000000;
        wStrb = 4'h0;
        {awValid, wValid, bReady, arValid, rReady} = 5'h00;
        fails = 0;
        compares = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        axiRead(IDX_PATH_EVT, FLAG_RESET, RESP_OKAY);
        axiRead(IDX_PTR_EVT, FLAG_RESET, RESP_OKAY);
        axiRead(IDX_PTR_EN, EN_RESET, RESP_OKAY);
        // Each flag alone, in its own byte only, gone after one read
        for (int i = 0; i < 8; i++) begin
            ev(8'h01 << i, 8'h00, 1'b0);
            axiRead(IDX_PTR_EVT, 8'h00, RESP_OKAY);
            axiRead(IDX_PATH_EVT, 8'h01 << i, RESP_OKAY);
            ev(8'h00, 8'h01 << i, 1'b0);
            axiRead(IDX_PATH_EVT, 8'h00, RESP_OKAY);
            axiRead(IDX_PTR_EVT, 8'h01 << i, RESP_OKAY);
        end
        // Recognised kinds hide the unknown flag; NDF hides a new pointer
        ev(8'h00, 8'h44, 1'b0);
        axiRead(IDX_PTR_EVT, 8'h04, RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            kind = (i < 4) ? KINDS[i] : 8'h00;
            ev(8'h00, kind | 8'h20, i == 4);
            axiRead(IDX_PTR_EVT, kind, RESP_OKAY);
        end
        // Repeated events stay one flag; an event in the read cycle survives
        ev(8'h00, 8'h80, 1'b0);
        ev(8'h00, 8'h80, 1'b0);
        axiRead(IDX_PTR_EVT, 8'h80, RESP_OKAY);
        ev(8'h80, 8'h00, 1'b0);
        fork
            axiRead(IDX_PATH_EVT, 8'h80, RESP_OKAY);
            ev(8'h40, 8'h00, 1'b0);
        join
        axiRead(IDX_PATH_EVT, 8'h40, RESP_OKAY);
        // Defect levels: live status and change flags on both edges
        for (int i = 0; i < 3; i++) begin
            i_vpef_det.drive(8'h00, 8'h00, 1'b0, LVS[i], 3'h5);
            axiRead(IDX_PATH_STATUS, STS[i], RESP_OKAY);
            axiRead(IDX_PATH_EVT, PES[i], RESP_OKAY);
            axiRead(IDX_PTR_EVT, PTS[i], RESP_OKAY);
        end
        axiRead(IDX_RDI_VALUE, 8'h50, RESP_OKAY);
        // Interrupt follows only enabled flags; flags ignore enables
        ev(8'h00, 8'h80, 1'b0);
        checkIrq(1'b0);
        axiWrite(IDX_PTR_EN, 8'h7F, 4'h1, RESP_OKAY);
        checkIrq(1'b0);
        axiWrite(IDX_PTR_EN, 8'h80, 4'h1, RESP_OKAY);
        checkIrq(1'b1);
        axiRead(IDX_PTR_EN, 8'h80, RESP_OKAY);
        axiRead(IDX_PTR_EVT, 8'h80, RESP_OKAY);
        checkIrq(1'b0);
        axiWrite(IDX_PATH_EN, 8'h01, 4'h1, RESP_OKAY);
        axiWrite(IDX_PATH_EN, 8'hFF, 4'h0, RESP_OKAY);
        axiRead(IDX_PATH_EN, 8'h01, RESP_OKAY);
        ev(8'h01, 8'h00, 1'b0);
        checkIrq(1'b1);
        axiWrite(IDX_PATH_EN, 8'h00, 4'h1, RESP_OKAY);
        checkIrq(1'b0);
        axiRead(IDX_PATH_EVT, 8'h01, RESP_OKAY);
        // Flags cannot be written; unmapped places answer with an error
        ev(8'h00, 8'h02, 1'b0);
        axiWrite(IDX_PTR_EVT, 8'h00, 4'h1, RESP_OKAY);
        axiRead(IDX_PTR_EVT, 8'h02, RESP_OKAY);
        axiWrite(14'h0100, 8'h12, 4'h1, RESP_SLVERR);
        axiRead(14'h0100, 8'h00, RESP_SLVERR);
        report_and_stop();
    end
endmodule : vpef_event_flags_tb
`default_nettype wire
